// file: display_deflection_pkg.sv
package display_deflection_pkg;

   // Register slots, byte address of each is four times its index.
   localparam int             NUM_REGS       = 19;
   localparam logic [9:0]     IDX_ANALOG_MATRIX_CONTROL     = 10'h116;
   localparam logic [9:0]     IDX_PWM_TWO_DUTY              = 10'h17b;
   localparam logic [9:0]     IDX_PWM_ONE_DUTY              = 10'h17c;
   localparam logic [9:0]     IDX_FREQUENCY_DOUBLING_CONTROL = 10'h17d;
   localparam logic [9:0]     IDX_VERTICAL_PWM_AND_EW_SCALE = 10'h17e;
   localparam logic [9:0]     IDX_EW_PICTURE_WIDTH          = 10'h19a;
   localparam logic [9:0]     IDX_EW_TRAPEZE_CORRECTION     = 10'h19b;
   localparam logic [9:0]     IDX_EW_CUSHION_CORRECTION     = 10'h19c;
   localparam logic [9:0]     IDX_EW_UPPER_CORNER           = 10'h19d;
   localparam logic [9:0]     IDX_EW_LOWER_CORNER           = 10'h19e;
   localparam logic [9:0]     IDX_EW_UPPER_CORNER_SIXTH     = 10'h19f;
   localparam logic [9:0]     IDX_EW_LOWER_CORNER_SIXTH     = 10'h1a0;
   localparam logic [9:0]     IDX_HV_SECOND_COEFF_THRESHOLD = 10'h1af;
   localparam logic [9:0]     IDX_HV_STATIC_TIME_CONSTANT   = 10'h1b0;
   localparam logic [9:0]     IDX_VERT_AMP_COMP_FIRST       = 10'h1b1;
   localparam logic [9:0]     IDX_VERT_AMP_COMP_SECOND      = 10'h1b2;
   localparam logic [9:0]     IDX_HORIZ_AMP_COMP_FIRST      = 10'h1b3;
   localparam logic [9:0]     IDX_HORIZ_AMP_COMP_SECOND     = 10'h1b4;
   localparam logic [9:0]     IDX_BLANK_CONTRAST_INPUT_MODE = 10'h1df;

   // Slot numbers inside the register file.
   localparam int S_MATRIX = 0;
   localparam int S_DUTY2  = 1;
   localparam int S_DUTY1  = 2;
   localparam int S_DBL    = 3;
   localparam int S_VDUTY  = 4;
   localparam int S_THRES  = 12;
   localparam int S_STC    = 13;
   localparam int S_VSA1   = 14;
   localparam int S_VSA2   = 15;
   localparam int S_HSA1   = 16;
   localparam int S_HSA2   = 17;
   localparam int S_BLANK  = 18;

   localparam logic [NUM_REGS-1:0][9:0] REG_INDEX = {
      IDX_BLANK_CONTRAST_INPUT_MODE, IDX_HORIZ_AMP_COMP_SECOND, IDX_HORIZ_AMP_COMP_FIRST,
      IDX_VERT_AMP_COMP_SECOND, IDX_VERT_AMP_COMP_FIRST, IDX_HV_STATIC_TIME_CONSTANT,
      IDX_HV_SECOND_COEFF_THRESHOLD, IDX_EW_LOWER_CORNER_SIXTH, IDX_EW_UPPER_CORNER_SIXTH,
      IDX_EW_LOWER_CORNER, IDX_EW_UPPER_CORNER, IDX_EW_CUSHION_CORRECTION,
      IDX_EW_TRAPEZE_CORRECTION, IDX_EW_PICTURE_WIDTH, IDX_VERTICAL_PWM_AND_EW_SCALE,
      IDX_FREQUENCY_DOUBLING_CONTROL, IDX_PWM_ONE_DUTY, IDX_PWM_TWO_DUTY, IDX_ANALOG_MATRIX_CONTROL};

   // Writable bits per slot; reserved bits are stored and read as zero.
   localparam logic [NUM_REGS-1:0][15:0] REG_MASK = {
      16'h1fff, 16'hffc0, 16'hffc0, 16'hffc0, 16'hffc0, 16'h7fc0, 16'h7fc0,
      16'hff00, 16'hff00, 16'hff00, 16'hff00, 16'hff00, 16'hff00, 16'hff80,
      16'h03ff, 16'h183f, 16'h00ff, 16'h00ff, 16'h7dc0};

   localparam logic [NUM_REGS-1:0][15:0] REG_RESET = {
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h7fc0,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1980,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   // Field positions.
   localparam int RASTER_ORDER_LSB = 0;
   localparam int FIELD_FILTER_LSB = 2;
   localparam int SYNC_DOUBLE_LSB  = 4;
   localparam int STILL_BIT        = 11;
   localparam int FIFO_POL_BIT     = 12;
   localparam int MATRIX_SEL_LSB   = 6;
   localparam int SATURATION_LSB   = 10;
   localparam int BLANK1_HIGH_BIT  = 0;
   localparam int BLANK_POL_BIT    = 1;
   localparam int BLANK1_LOW_BIT   = 2;
   localparam int BLANK_PRIO_BIT   = 3;
   localparam int BLANK2_LOW_BIT   = 4;
   localparam int BLANK2_HIGH_BIT  = 5;
   localparam int BLANK_MON_BIT    = 6;
   localparam int CLAMP_EN_BIT     = 7;
   localparam int CLAMP_VB_BIT     = 8;
   localparam int HC_POL_BIT       = 9;
   localparam int HC_EN_BIT        = 10;
   localparam int HC_FORCE_BIT     = 11;
   localparam int HC_DEPTH_BIT     = 12;
   localparam int DUTY_LSB         = 0;
   localparam int EW_SCALE_BIT     = 0;
   localparam int PARABOLA_SEL_BIT = 1;
   localparam int VDUTY_LSB        = 2;
   localparam int COEF_LSB         = 6;

   // Static time constant unit of 0.025 ms at the 50 MHz system clock.
   localparam int             CLK_PERIOD_NS   = 20;
   localparam int             STC_UNIT_NS     = 25000;
   localparam logic [10:0]    STC_UNIT_CYCLES = 11'((STC_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0]     PARABOLA_CENTRE = 9'h080;

   typedef enum logic [2:0] {MATRIX_YUV, MATRIX_RGB, MATRIX_480P, MATRIX_1080I, MATRIX_NONE} matrix_e;
   typedef enum logic [1:0] {PH_FIRST, PH_SECOND, PH_THIRD, PH_FOURTH} phase_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_s;

   typedef struct packed {
      logic        fieldStrobe;
      logic        rasterLost;
      logic [3:0]  fifoCtl;
      logic        blankInputOne;
      logic        blankInputTwo;
      logic        clampPulse;
      logic        vBlank;
      logic        halfContrastPin;
      logic [7:0]  vPos;
      logic [7:0]  ewValue;
      logic [7:0]  lineScale;
      logic [10:0] highTensionLevel;
   } video_in_s;

   typedef struct packed {
      logic              srcFieldB;
      logic              rasterB;
      logic              doublingLocked;
      logic              doubleVsync;
      logic              doubleHsync;
      logic              stillPicture;
      logic [3:0]        fifoPins;
      matrix_e           matrixSel;
      logic [4:0]        saturation;
      logic              blankActive;
      logic              blankFromTwo;
      logic              blankMonitor;
      logic              clampOut;
      logic              halfContrast;
      logic              halfContrastDeep;
      logic              pwmOne;
      logic              pwmTwo;
      logic              pwmVert;
      logic              pwmEw;
      logic signed [9:0] vertCoef;
      logic signed [9:0] horizCoef;
      logic              staticCompOn;
      logic              staticCompTick;
   } video_out_s;

   typedef struct packed {
      logic [NUM_REGS-1:0][15:0] regs;
      logic [31:0]               prdata;
      phase_e                    phase;
      logic [2:0]                fieldsSeen;
      logic [7:0]                pwmCnt;
      logic [10:0]               unitCnt;
      logic [8:0]                stcCnt;
      video_out_s                out;
   } state_s;

endpackage

// file: display_deflection_control_regs.sv
// Register access over APB was left to the implementer.
`timescale 1ns/10ps

// What this block does
// - Two-bit raster mode orders the four output fields and their rasters.
// - Two-bit filter requires off, 2, 3 or 4 fields before doubling locks.
// - Two-bit switch doubles none, vertical, horizontal or both sync pulses.
// - Still picture bit freezes the picture only while doubling is active.
// - FIFO control pins are active high with polarity 0, low with 1.
// - Three-bit field picks YUV, RGB, 480P or 1080I input matrix.
// - Five-bit value 0 to 31 scales inserted analog saturation.
// - Each blank input passes its pin unless force high or low overrides.
// - Blank pin polarity bit selects active high (0) or active low (1).
// - With both blank inputs active the priority bit picks one or two.
// - Monitor select bit routes blank input one (0) or two (1).
// - Analog RGB inputs are clamped only while clamp enable is set.
// - Clamp vertical blank bit suppresses the clamp pulse in vertical blanking.
// - Half contrast pin polarity bit selects active high (0) or low (1).
// - Half contrast acts only when enabled; force bit holds it high.
// - Half contrast depth bit selects -6 dB (0) or -10 dB (1).
// - Two independent 8-bit PWM outputs with duty 0 to 255.
// - Third PWM is static duty, or parabola amplitude when selected.
// - East-west PWM uses full range, or scales to line length when set.
// - Second high-tension coefficients take over above a programmable threshold.
// - Static time constant zero turns compensation off, else sets its period.
module display_deflection_control_regs
   import display_deflection_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // Register bus
   input  wire apb_req_s   apbReq,
   output apb_rsp_s        apbRsp,
   // Video and deflection side
   input  wire video_in_s  videoIn,
   output video_out_s      videoOut
);

   typedef struct packed {
      logic       hit;
      logic [4:0] slot;
   } decode_s;

   state_s cur;
   state_s next_cur;

   // Word addresses only; a byte offset within the word is unmapped.
   function automatic decode_s decodeAddr(input logic [11:0] addr);
      decode_s d;
      d.hit  = 1'b0;
      d.slot = 5'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (addr[1:0] == 2'b00 && addr[11:2] == REG_INDEX[i]) begin
            d.hit  = 1'b1;
            d.slot = 5'(i);
         end
      end
      return d;
   endfunction

   // Polarity-corrected view of an input pin.
   function automatic logic activeLevel(input logic pin, input logic lowActive);
      return pin ^ lowActive;
   endfunction

   // Forced value wins over the pin; force high beats force low if both are set.
   function automatic logic forcedBlank(input logic level, input logic forceHigh, input logic forceLow);
      if (forceHigh) begin
         return 1'b1;
      end else if (forceLow) begin
         return 1'b0;
      end
      return level;
   endfunction

   decode_s    dec;
   logic       setup;
   logic       access;
   logic [1:0] rasterMode;
   logic [1:0] filterSel;
   logic [1:0] syncSwitch;
   logic       fifoLow;
   logic [2:0] matrixCode;
   logic [7:0] blankReg;
   logic [12:0] blankMode;
   logic       level1;
   logic       level2;
   logic       blank1;
   logic       blank2;
   logic       doublingOn;
   logic [8:0] vOffset;
   logic [6:0] vMag;
   logic [13:0] vSquare;
   logic [15:0] parabolaProd;
   logic [15:0] ewProd;
   logic [7:0] vertDuty;
   logic [7:0] ewDuty;
   logic [8:0] threshold;
   logic [8:0] stcValue;
   logic       useSecond;
   logic [15:0] vpwmReg;

   assign dec    = decodeAddr(apbReq.paddr);
   assign setup  = apbReq.psel & ~apbReq.penable;
   assign access = apbReq.psel & apbReq.penable;

   // Zero-wait slave: read data is captured in the setup cycle, so the access cycle always completes.
   assign apbRsp.pready  = access;
   assign apbRsp.pslverr = access & ~dec.hit;
   assign apbRsp.prdata  = cur.prdata;
   assign videoOut       = cur.out;

   assign rasterMode = cur.regs[S_DBL][RASTER_ORDER_LSB +: 2];
   assign filterSel  = cur.regs[S_DBL][FIELD_FILTER_LSB +: 2];
   assign syncSwitch = cur.regs[S_DBL][SYNC_DOUBLE_LSB +: 2];
   assign fifoLow    = cur.regs[S_DBL][FIFO_POL_BIT];
   assign matrixCode = cur.regs[S_MATRIX][MATRIX_SEL_LSB +: 3];
   assign blankMode  = cur.regs[S_BLANK][12:0];
   assign blankReg   = blankMode[7:0];
   assign vpwmReg    = cur.regs[S_VDUTY];
   assign threshold  = cur.regs[S_THRES][COEF_LSB +: 9];
   assign stcValue   = cur.regs[S_STC][COEF_LSB +: 9];

   always_comb begin
      next_cur = cur;

      // Register bus.
      if (setup) begin
         next_cur.prdata = dec.hit ? {16'h0000, cur.regs[dec.slot]} : 32'h0000_0000;
      end
      if (access && apbReq.pwrite && dec.hit) begin
         // Reserved bits are dropped on write, so they read back as zero.
         next_cur.regs[dec.slot] = apbReq.pwdata[15:0] & REG_MASK[dec.slot];
      end

      // Field sequencing for the doubled display.
      if (videoIn.rasterLost) begin
         next_cur.phase      = PH_FIRST;
         next_cur.fieldsSeen = 3'h0;
      end else if (videoIn.fieldStrobe) begin
         case (cur.phase)
            PH_FIRST:  next_cur.phase = PH_SECOND;
            PH_SECOND: next_cur.phase = PH_THIRD;
            PH_THIRD:  next_cur.phase = PH_FOURTH;
            PH_FOURTH: next_cur.phase = PH_FIRST;
            default:   next_cur.phase = PH_FIRST;
         endcase
         if (cur.fieldsSeen != 3'h4) begin
            next_cur.fieldsSeen = cur.fieldsSeen + 3'h1;
         end
      end

      next_cur.out.srcFieldB = (next_cur.phase == PH_THIRD) || (next_cur.phase == PH_FOURTH);
      case (rasterMode)
         2'd0:    next_cur.out.rasterB = (next_cur.phase == PH_SECOND) || (next_cur.phase == PH_FOURTH);
         2'd1:    next_cur.out.rasterB = next_cur.out.srcFieldB;
         2'd2:    next_cur.out.rasterB = 1'b0;
         default: next_cur.out.rasterB = next_cur.out.srcFieldB;
      endcase

      // Code 0 bypasses the filter; code n needs n+1 consecutive fields.
      next_cur.out.doublingLocked = (filterSel == 2'd0) ||
                                    (next_cur.fieldsSeen >= ({1'b0, filterSel} + 3'h1));

      next_cur.out.doubleVsync = syncSwitch[0];
      next_cur.out.doubleHsync = syncSwitch[1];
      doublingOn = (syncSwitch != 2'd0) && next_cur.out.doublingLocked;
      next_cur.out.stillPicture = cur.regs[S_DBL][STILL_BIT] & doublingOn;
      next_cur.out.fifoPins = videoIn.fifoCtl ^ {4{fifoLow}};

      // Analog insertion.
      case (matrixCode)
         3'd0:    next_cur.out.matrixSel = MATRIX_YUV;
         3'd1:    next_cur.out.matrixSel = MATRIX_RGB;
         3'd2:    next_cur.out.matrixSel = MATRIX_480P;
         3'd4:    next_cur.out.matrixSel = MATRIX_1080I;
         default: next_cur.out.matrixSel = MATRIX_NONE;
      endcase
      next_cur.out.saturation = cur.regs[S_MATRIX][SATURATION_LSB +: 5];

      // Fast blank.
      level1 = activeLevel(videoIn.blankInputOne, blankReg[BLANK_POL_BIT]);
      level2 = activeLevel(videoIn.blankInputTwo, blankReg[BLANK_POL_BIT]);
      blank1 = forcedBlank(level1, blankReg[BLANK1_HIGH_BIT], blankReg[BLANK1_LOW_BIT]);
      blank2 = forcedBlank(level2, blankReg[BLANK2_HIGH_BIT], blankReg[BLANK2_LOW_BIT]);
      next_cur.out.blankActive = blank1 | blank2;
      if (blank1 && blank2) begin
         next_cur.out.blankFromTwo = blankReg[BLANK_PRIO_BIT];
      end else begin
         next_cur.out.blankFromTwo = blank2;
      end
      next_cur.out.blankMonitor = blankReg[BLANK_MON_BIT] ? level2 : level1;

      // Clamp pulse for both analog inputs.
      next_cur.out.clampOut = blankReg[CLAMP_EN_BIT] & videoIn.clampPulse &
                              ~(blankMode[CLAMP_VB_BIT] & videoIn.vBlank);

      // Half contrast.
      next_cur.out.halfContrast = blankMode[HC_EN_BIT] &
                                  (blankMode[HC_FORCE_BIT] |
                                   activeLevel(videoIn.halfContrastPin, blankMode[HC_POL_BIT]));
      next_cur.out.halfContrastDeep = blankMode[HC_DEPTH_BIT];

      // PWM outputs share one free-running ramp; duty 255 gives 255 of 256 high.
      next_cur.pwmCnt      = cur.pwmCnt + 8'h01;
      next_cur.out.pwmOne  = cur.pwmCnt < cur.regs[S_DUTY1][DUTY_LSB +: 8];
      next_cur.out.pwmTwo  = cur.pwmCnt < cur.regs[S_DUTY2][DUTY_LSB +: 8];

      // The parabola is centred on the middle of the field, clipped to keep it in 8 bits.
      vOffset      = {1'b0, videoIn.vPos} - PARABOLA_CENTRE;
      vMag         = (vOffset == 9'h180) ? 7'h7f : (vOffset[8] ? 7'((~vOffset) + 9'h001) : vOffset[6:0]);
      vSquare      = vMag * vMag;
      parabolaProd = vSquare[13:6] * vpwmReg[VDUTY_LSB +: 8];
      vertDuty     = vpwmReg[PARABOLA_SEL_BIT] ? parabolaProd[15:8] : vpwmReg[VDUTY_LSB +: 8];
      next_cur.out.pwmVert = cur.pwmCnt < vertDuty;

      ewProd = videoIn.ewValue * videoIn.lineScale;
      ewDuty = vpwmReg[EW_SCALE_BIT] ? ewProd[15:8] : videoIn.ewValue;
      next_cur.out.pwmEw = cur.pwmCnt < ewDuty;

      // High-tension compensation: the level is compared in the threshold's 9-bit resolution.
      useSecond = videoIn.highTensionLevel[10:2] > threshold;
      next_cur.out.vertCoef  = useSecond ? $signed(cur.regs[S_VSA2][COEF_LSB +: 10])
                                         : $signed(cur.regs[S_VSA1][COEF_LSB +: 10]);
      next_cur.out.horizCoef = useSecond ? $signed(cur.regs[S_HSA2][COEF_LSB +: 10])
                                         : $signed(cur.regs[S_HSA1][COEF_LSB +: 10]);

      next_cur.out.staticCompOn   = stcValue != 9'h000;
      next_cur.out.staticCompTick = 1'b0;
      if (stcValue == 9'h000) begin
         next_cur.unitCnt = 11'h000;
         next_cur.stcCnt  = 9'h000;
      end else if (cur.unitCnt == STC_UNIT_CYCLES - 11'h001) begin
         next_cur.unitCnt = 11'h000;
         if (cur.stcCnt >= stcValue - 9'h001) begin
            next_cur.stcCnt             = 9'h000;
            next_cur.out.staticCompTick = 1'b1;
         end else begin
            next_cur.stcCnt = cur.stcCnt + 9'h001;
         end
      end else begin
         next_cur.unitCnt = cur.unitCnt + 11'h001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cur            <= '0;
         cur.regs       <= REG_RESET;
         cur.phase      <= PH_FIRST;
         cur.out.matrixSel <= MATRIX_YUV;
      end else begin
         cur <= next_cur;
      end
   end

endmodule

// file: display_deflection_control_regs_monitor.sv
`timescale 1ns/10ps

module display_deflection_control_regs_monitor
   import display_deflection_pkg::*;
(
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rstn,
   // Register bus
   input wire apb_req_s   apbReq,
   input wire apb_rsp_s   apbRsp,
   // Video and deflection side
   input wire video_in_s  videoIn,
   input wire video_out_s videoOut
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   wire logic acc = apbReq.psel && apbReq.penable;

   // Decoding is redone here from the slot list so a wrong compare in the design shows up.
   function automatic logic mapped(input logic [11:0] a);
      mapped = 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
         mapped |= (a == {REG_INDEX[i], 2'b00});
      end
   endfunction

   zero_wait_a: assert property (acc |-> apbRsp.pready)
      else $error("access cycle without ready");
   decode_error_a: assert property (acc |-> apbRsp.pslverr == !mapped(apbReq.paddr))
      else $error("error response does not match the address");
   error_data_a: assert property (acc && apbRsp.pslverr |-> apbRsp.prdata == 32'h0)
      else $error("refused access returned data");
   upper_zero_a: assert property (acc |-> apbRsp.prdata[31:16] == 16'h0)
      else $error("read data upper half not zero");
   read_hold_a: assert property (acc |=> $stable(apbRsp.prdata))
      else $error("read data changed right after the access");
   fifo_follow_a: assert property ($past(rstn) |->
      videoOut.fifoPins == $past(videoIn.fifoCtl) || videoOut.fifoPins == ~$past(videoIn.fifoCtl))
      else $error("fifo pins neither follow nor invert the strobes");
   still_lock_a: assert property (videoOut.stillPicture |->
      videoOut.doublingLocked && (videoOut.doubleVsync || videoOut.doubleHsync))
      else $error("still picture without active doubling");
   tick_on_a: assert property (videoOut.staticCompTick |-> videoOut.staticCompOn)
      else $error("compensation tick while compensation is off");
   tick_pulse_a: assert property (videoOut.staticCompTick |=> !videoOut.staticCompTick [*8])
      else $error("compensation ticks too close together");
endmodule

bind display_deflection_control_regs display_deflection_control_regs_monitor i_monitor (
   .sys_clk  (sys_clk),
   .rstn     (rstn),
   .apbReq   (apbReq),
   .apbRsp   (apbRsp),
   .videoIn  (videoIn),
   .videoOut (videoOut)
);

// file: tb_display_deflection_control_regs.sv
`timescale 1ns/10ps

module tb_display_deflection_control_regs
   import display_deflection_pkg::*;
;
   typedef struct packed {logic [9:0] idx; logic [15:0] rst; logic [15:0] msk;} reg_row_s;
   typedef struct packed {logic [15:0] mode; logic [4:0] pins; logic [5:0] exp; logic [5:0] care;} vid_row_s;

   logic        sys_clk;
   logic        rstn;
   apb_req_s    req;
   apb_rsp_s    rsp;
   video_in_s   vin;
   video_out_s  vout;
   int          error_cnt;
   int          check_count;
   logic [31:0] rd;
   logic        err;
   int          n1, n2, nv, ne;

   localparam reg_row_s REGS [19] = '{
      '{10'h116, 16'h0000, 16'h7dc0}, '{10'h17b, 16'h0000, 16'h00ff}, '{10'h17c, 16'h0000, 16'h00ff},
      '{10'h17d, 16'h0000, 16'h183f}, '{10'h17e, 16'h0000, 16'h03ff}, '{10'h19a, 16'h1980, 16'hff80},
      '{10'h19b, 16'h0000, 16'hff00}, '{10'h19c, 16'h0000, 16'hff00}, '{10'h19d, 16'h0000, 16'hff00},
      '{10'h19e, 16'h0000, 16'hff00}, '{10'h19f, 16'h0000, 16'hff00}, '{10'h1a0, 16'h0000, 16'hff00},
      '{10'h1af, 16'h7fc0, 16'h7fc0}, '{10'h1b0, 16'h0000, 16'h7fc0}, '{10'h1b1, 16'h0000, 16'hffc0},
      '{10'h1b2, 16'h0000, 16'hffc0}, '{10'h1b3, 16'h0000, 16'hffc0}, '{10'h1b4, 16'h0000, 16'hffc0},
      '{10'h1df, 16'h0000, 16'h1fff}};
   // Pins: one, two, contrast, clamp, vblank. Results: active, from two, monitor, contrast, deep, clamp.
   localparam vid_row_s VIDS [15] = '{
      '{16'h0000, 5'b10000, 6'b101000, 6'b111101}, '{16'h0040, 5'b10000, 6'b100000, 6'b111000},
      '{16'h0001, 5'b00000, 6'b100000, 6'b111000}, '{16'h0020, 5'b00000, 6'b110000, 6'b110000},
      '{16'h0008, 5'b11000, 6'b110000, 6'b110000}, '{16'h000a, 5'b00000, 6'b110000, 6'b110000},
      '{16'h0014, 5'b11000, 6'b000000, 6'b100000}, '{16'h0400, 5'b00100, 6'b000100, 6'b000110},
      '{16'h0000, 5'b00110, 6'b000000, 6'b000101}, '{16'h0600, 5'b00000, 6'b000100, 6'b000100},
      '{16'h0c00, 5'b00000, 6'b000100, 6'b000100}, '{16'h1400, 5'b00100, 6'b000110, 6'b000110},
      '{16'h0080, 5'b00011, 6'b000001, 6'b000001}, '{16'h0180, 5'b00011, 6'b000000, 6'b000001},
      '{16'h0180, 5'b00010, 6'b000001, 6'b000001}};
   localparam matrix_e MX [8] = '{MATRIX_YUV, MATRIX_RGB, MATRIX_480P, MATRIX_NONE,
                                  MATRIX_1080I, MATRIX_NONE, MATRIX_NONE, MATRIX_NONE};
   localparam logic [3:0] RB [3] = '{4'b1010, 4'b1100, 4'b0000};

   display_deflection_control_regs i_dut (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .apbReq   (req),
      .apbRsp   (rsp),
      .videoIn  (vin),
      .videoOut (vout)
   );

   initial begin
      sys_clk = 1'b0;
      forever begin
         #10 sys_clk = ~sys_clk;
      end
   end

   task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // The bus is left in its access phase so that a following transfer may start back to back.
   task automatic bus(input logic wr, input logic [11:0] addr, input logic [15:0] wd);
      int n;
      n = 0;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: {16'h0000, wd}};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         summarize();
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
   endtask

   task automatic wreg(input logic [9:0] idx, input logic [15:0] wd);
      bus(1'b1, {idx, 2'b00}, wd);
   endtask

   task automatic tick(input int k);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      repeat (k) @(posedge sys_clk);
   endtask

   task automatic pulse(output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (vout.staticCompTick !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         error_cnt++;
         summarize();
      end
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end

   initial begin
      error_cnt = 0;
      check_count = 0;
      rstn = 1'b0;
      req = '0;
      vin = '0;
      vin.fifoCtl = 4'h5;
      vin.vPos = 8'h00;
      vin.ewValue = 8'h80;
      vin.lineScale = 8'h40;
      vin.highTensionLevel = 11'h003;
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      tick(2);
      for (int i = 0; i < 19; i++) begin
         bus(1'b0, {REGS[i].idx, 2'b00}, 16'h0000);
         chk({16'h0, REGS[i].rst}, rd, "reset value");
         wreg(REGS[i].idx, REGS[i].msk);
         bus(1'b0, {REGS[i].idx, 2'b00}, 16'h0000);
         chk({16'h0, REGS[i].msk}, rd, "writable bits");
      end
      bus(1'b1, 12'h000, 16'h1234);
      chk(32'h80000000, {err, 31'h0}, "unmapped write");
      bus(1'b0, 12'h459, 16'h0000);
      chk(32'h80000000, {err, rd[30:0]}, "misaligned read");
      tick(2);
      chk(32'ha, {28'h0, vout.fifoPins}, "fifo pins low active");
      for (int c = 0; c < 4; c++) begin
         wreg(IDX_FREQUENCY_DOUBLING_CONTROL, 16'(16'h0800 | (c << 4)));
         tick(2);
         chk({29'h0, c != 0, 2'(c)}, {29'h0, vout.stillPicture, vout.doubleHsync, vout.doubleVsync},
             "sync doubling");
      end
      chk(32'h5, {28'h0, vout.fifoPins}, "fifo pins high active");
      for (int m = 0; m < 3; m++) begin
         wreg(IDX_FREQUENCY_DOUBLING_CONTROL, 16'(m | ((m + 1) << 2)));
         vin.rasterLost <= 1'b1;
         tick(1);
         vin.rasterLost <= 1'b0;
         for (int k = 0; k < 5; k++) begin
            tick(2);
            chk({29'h0, RB[m][k % 4], k >= m + 2, (k % 4) >= 2},
                {29'h0, vout.rasterB, vout.doublingLocked, vout.srcFieldB}, "raster");
            vin.fieldStrobe <= 1'b1;
            tick(1);
            vin.fieldStrobe <= 1'b0;
         end
      end
      for (int c = 0; c < 8; c++) begin
         wreg(IDX_ANALOG_MATRIX_CONTROL, 16'(((c * 4 + 3) << 10) | (c << 6)));
         tick(2);
         chk({24'h0, 5'(c * 4 + 3), MX[c]}, {24'h0, vout.saturation, vout.matrixSel}, "matrix");
      end
      for (int i = 0; i < 15; i++) begin
         wreg(IDX_BLANK_CONTRAST_INPUT_MODE, VIDS[i].mode);
         {vin.blankInputOne, vin.blankInputTwo, vin.halfContrastPin, vin.clampPulse, vin.vBlank} <= VIDS[i].pins;
         tick(2);
         chk({26'h0, VIDS[i].exp}, {26'h0, VIDS[i].care &
             {vout.blankActive, vout.blankFromTwo, vout.blankMonitor, vout.halfContrast, vout.halfContrastDeep,
             vout.clampOut}}, "blank and contrast");
      end
      // Second pass runs the parabola on the first line, where the distance from centre clips to 127.
      for (int p = 0; p < 2; p++) begin
         wreg(IDX_PWM_ONE_DUTY, p ? 16'h0000 : 16'h0040);
         wreg(IDX_PWM_TWO_DUTY, p ? 16'h0080 : 16'h00ff);
         wreg(IDX_VERTICAL_PWM_AND_EW_SCALE, p ? 16'h03ff : 16'h0004);
         tick(3);
         {n1, n2, nv, ne} = '0;
         repeat (256) begin
            @(posedge sys_clk);
            n1 += (vout.pwmOne === 1'b1);
            n2 += (vout.pwmTwo === 1'b1);
            nv += (vout.pwmVert === 1'b1);
            ne += (vout.pwmEw === 1'b1);
         end
         chk(p ? 32'd0 : 32'd64, n1, "first duty");
         chk(p ? 32'd128 : 32'd255, n2, "second duty");
         chk(p ? 32'd251 : 32'd1, nv, "third duty");
         chk(p ? 32'd32 : 32'd128, ne, "east west duty");
      end
      wreg(IDX_VERT_AMP_COMP_FIRST, 16'hffc0);
      wreg(IDX_HORIZ_AMP_COMP_FIRST, 16'h7fc0);
      wreg(IDX_VERT_AMP_COMP_SECOND, 16'h8000);
      wreg(IDX_HORIZ_AMP_COMP_SECOND, 16'h0040);
      wreg(IDX_HV_SECOND_COEFF_THRESHOLD, 16'h0000);
      tick(2);
      chk({12'h0, 20'hffdff}, {12'h0, vout.vertCoef, vout.horizCoef}, "first coefficients");
      vin.highTensionLevel <= 11'h004;
      tick(2);
      chk({12'h0, 20'h80001}, {12'h0, vout.vertCoef, vout.horizCoef}, "second coefficients");
      wreg(IDX_HV_STATIC_TIME_CONSTANT, 16'h0000);
      tick(2);
      chk(32'h0, {31'h0, vout.staticCompOn}, "compensation off");
      wreg(IDX_HV_STATIC_TIME_CONSTANT, 16'h0040);
      tick(0);
      pulse(n1);
      pulse(n1);
      chk(32'd1250, n1, "tick spacing");
      summarize();
   end
endmodule
